/* rtl/sps_defs.vh */
`ifndef SPS_DEFS_VH
`define SPS_DEFS_VH

// register offsets on the plain register port
`define SPS_ADDR_W      2
`define SPS_OFS_CTRL    2'h0
`define SPS_OFS_STAT    2'h1
`define SPS_OFS_DATA    2'h2

// control register fields
`define SPS_C_SELECT_OUTPUT_ENABLE      7
`define SPS_C_EN        6
`define SPS_C_LSB       5
`define SPS_C_MASTER_SELECT_BIT      4
`define SPS_C_CPOL      3
`define SPS_C_CPHA      2
`define SPS_C_RATE_HI   1
`define SPS_C_RATE_LO   0
`define SPS_CFG_HI      5

// status register fields
`define SPS_S_DONE      7
`define SPS_S_WRITE_COLLISION_FLAG      6
`define SPS_S_OVF       5
`define SPS_S_MODE_FAULT_FLAG      4
`define SPS_S_DISM      3

// reset values
`define SPS_CTRL_RST    8'h00
`define SPS_DATA_RST    8'h00

// shift clock half period at the fastest rate, in system clocks (F/4)
`define SPS_HALF_MIN    5'h02
// last of the sixteen shift clock edges of one byte
`define SPS_EDGE_LAST   4'hf
// last bit index of one byte
`define SPS_BIT_LAST    4'h7
`define SPS_BITS        4'h8

`endif

/* rtl/sps_sync.v */
`timescale 1ns/100ps

module sps_sync #(
   parameter W = 4
) (
   // clock and reset
   input  wire         REF_CLK,
   input  wire         SYS_RST,
   // asynchronous levels in, synchronous levels out
   input  wire [W-1:0] D,
   output wire [W-1:0] Q
);

   reg [W-1:0] stage1;
   reg [W-1:0] stage2;

   // reset to all ones: idle level of select and data lines
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         stage1 <= {W{1'b1}};
         stage2 <= {W{1'b1}};
      end else begin
         stage1 <= D;
         stage2 <= stage1;
      end
   end

   assign Q = stage2;

endmodule

/* rtl/sps_top.v */
// Behaviour
// - master or slave operation; shift clock never faster than system clock/4
// - received bytes are copied into a read buffer, freeing the shifter
// - master-out driven as master, sampled as slave; master-in the reverse
// - shift clock pin is an output as master, an input as slave
// - master gives exactly eight shift clocks per byte, then stops
// - slave responds only while select is low
// - master auto select goes low per byte, high between bytes
// - shift out and in together; both shifters exchange contents
// - msb first by default, lsb first when set; register layout unchanged
// - master select pin: fault input, general I/O or automatic output
// - in slave mode the select pin is always the select input
// - master-select set: a data write starts a transfer
// - master byte done: flag set, received byte into data register
// - master-select clear: clock and select pins are inputs
// - slave exchanges nothing until select is pulled low
// - select high mid-byte: abort, fill remaining bits with ones, idle
// - slave byte done: into read buffer, flag set; data reads buffer
// - polarity sets idle clock level, phase picks the sampling edge
// - fault input low while master: clear master and enable, flag it
// - data write during a transfer flags collision, byte discarded
// - byte done with flag still set: overrun, new byte dropped
`timescale 1ns/100ps
`include "sps_defs.vh"

module sps_top (
   // system
   input  wire                   REF_CLK,
   input  wire                   SYS_RST,
   // register port
   input  wire [`SPS_ADDR_W-1:0] ADDR,
   input  wire [7:0]             WDATA,
   input  wire                   WR,
   input  wire                   RD,
   output reg  [7:0]             RDATA,
   // shift clock pin
   input  wire                   SCK_I,
   output wire                   SCK_O,
   output wire                   SCK_OE_N,
   // master-out line
   input  wire                   MOSI_I,
   output wire                   MOSI_O,
   output wire                   MOSI_OE_N,
   // master-in line
   input  wire                   MISO_I,
   output wire                   MISO_O,
   output wire                   MISO_OE_N,
   // select pin, active low
   input  wire                   SS_N_I,
   output wire                   SS_N_O,
   output wire                   SS_N_OE_N
);

   localparam M_IDLE  = 2'h0;
   localparam M_LEAD  = 2'h1;
   localparam M_SHIFT = 2'h2;
   localparam M_TAIL  = 2'h3;

   reg  [7:0] ctrl;
   reg        done_flag;
   reg        write_collision_flag_flag;
   reg        ovf_flag;
   reg        mode_fault_flag_flag;
   reg        fault_disable;
   reg  [7:0] shifter;
   reg  [7:0] rd_buf;
   reg        out_bit;
   reg  [1:0] m_state;
   reg  [4:0] div_cnt;
   reg  [3:0] edge_cnt;
   reg        sck_q;
   reg        ss_q;
   reg  [3:0] s_cnt;
   reg        sck_d;
   reg        ss_d;
   reg  [1:0] m_pipe;

   wire [3:0] pin_s;
   wire       sck_s;
   wire       mosi_s;
   wire       miso_s;
   wire       ss_s;

   // all four pins cross into the system clock before use
   sps_sync #(
      .W (4)
   ) u_sync (
      .REF_CLK (REF_CLK),
      .SYS_RST (SYS_RST),
      .D       ({SS_N_I, MISO_I, MOSI_I, SCK_I}),
      .Q       (pin_s)
   );

   assign sck_s  = pin_s[0];
   assign mosi_s = pin_s[1];
   assign miso_s = pin_s[2];
   assign ss_s   = pin_s[3];

   function [7:0] shift_in;
      input [7:0] v;
      input       b;
      input       lsb;
      begin
         if (lsb)
            shift_in = {b, v[7:1]};
         else
            shift_in = {v[6:0], b};
      end
   endfunction

   function top_bit;
      input [7:0] v;
      input       lsb;
      begin
         top_bit = lsb ? v[0] : v[7];
      end
   endfunction

   // pad an aborted byte with ones for the bits never received
   function [7:0] fill_ones;
      input [7:0] v;
      input [3:0] got;
      input       lsb;
      reg   [7:0] r;
      reg   [3:0] k;
      begin
         r = v;
         for (k = 4'h0; k < `SPS_BITS; k = k + 4'h1) begin
            if (k < `SPS_BITS - got)
               r = shift_in(r, 1'b1, lsb);
         end
         fill_ones = r;
      end
   endfunction

   // divisor 4, 8, 16 or 32 of the system clock
   function [4:0] half_len;
      input [1:0] rate;
      begin
         half_len = `SPS_HALF_MIN << rate;
      end
   endfunction

   wire       en      = ctrl[`SPS_C_EN];
   wire       master_select_bit    = ctrl[`SPS_C_MASTER_SELECT_BIT];
   wire       lsb     = ctrl[`SPS_C_LSB];
   wire       cpol    = ctrl[`SPS_C_CPOL];
   wire       cpha    = ctrl[`SPS_C_CPHA];
   wire       select_output_enable    = ctrl[`SPS_C_SELECT_OUTPUT_ENABLE];
   wire [1:0] rate    = ctrl[`SPS_C_RATE_HI:`SPS_C_RATE_LO];

   wire       master  = en & master_select_bit;
   wire       slave   = en & ~master_select_bit;
   wire       ss_low  = ~ss_s;

   wire       ctrl_wr = WR & (ADDR == `SPS_OFS_CTRL);
   wire       stat_wr = WR & (ADDR == `SPS_OFS_STAT);
   wire       data_wr = WR & (ADDR == `SPS_OFS_DATA);

   // fault input only when detection is not disabled
   wire       fault   = master & ~fault_disable & ss_low;

   // reconfiguring an enabled master kills the byte in flight; a slave byte carries on
   wire       cfg_abort = ctrl_wr & en &
                          (WDATA[`SPS_CFG_HI:0] != ctrl[`SPS_CFG_HI:0]);

   wire       s_act   = slave & ss_low;
   wire       m_busy  = (m_state != M_IDLE);
   wire       busy    = m_busy | s_act;
   wire       collide = data_wr & busy;
   wire       load_ok = data_wr & ~busy;
   wire       m_start = load_ok & master & ~fault;

   wire [4:0] half    = half_len(rate);
   wire       tick    = (div_cnt == half - 5'h01);

   // edge_cnt even: leading edge away from idle level
   wire       m_edge   = (m_state == M_SHIFT) & tick;
   wire       m_lead   = ~edge_cnt[0];
   wire       m_sample = m_edge & (m_lead ^ cpha);
   wire       m_launch = m_edge & ~(m_lead ^ cpha);
   // the line reaches us two flops late; take the bit once it has caught up
   wire       m_take   = m_pipe[1];

   // slave edges from the synchronised clock pin
   wire       s_rise   = sck_s & ~sck_d;
   wire       s_fall   = ~sck_s & sck_d;
   wire       s_lead   = cpol ? s_fall : s_rise;
   wire       s_trail  = cpol ? s_rise : s_fall;
   wire       s_sample = s_act & (cpha ? s_trail : s_lead);
   wire       s_launch = s_act & (cpha ? s_lead : s_trail);
   wire       s_ss_fall = slave & ss_low & ss_d;
   wire       s_abort  = slave & ~ss_low & (s_cnt != 4'h0);
   wire       s_done   = s_sample & (s_cnt == `SPS_BIT_LAST);

   wire       m_done   = (m_state == M_TAIL) & tick;
   wire       in_bit   = master ? miso_s : mosi_s;
   wire [7:0] shifted  = shift_in(shifter, in_bit, lsb);
   wire       xfer_done = m_done | s_done;
   wire [7:0] rx_val   = (s_done | m_take) ? shifted : shifter;

   wire       clr_done = stat_wr & WDATA[`SPS_S_DONE];
   wire       clr_write_collision_flag = stat_wr & WDATA[`SPS_S_WRITE_COLLISION_FLAG];
   wire       clr_ovf  = stat_wr & WDATA[`SPS_S_OVF];
   wire       clr_mode_fault_flag = stat_wr & WDATA[`SPS_S_MODE_FAULT_FLAG];
   // a clear in the same cycle counts as read in time
   wire       overrun  = xfer_done & done_flag & ~clr_done;

   // control register; a mode fault drops master and enable
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         ctrl <= `SPS_CTRL_RST;
      end else begin
         if (ctrl_wr)
            ctrl <= WDATA;
         if (fault) begin
            ctrl[`SPS_C_EN]   <= 1'b0;
            ctrl[`SPS_C_MASTER_SELECT_BIT] <= 1'b0;
         end
      end
   end

   // status flags, set wins over a simultaneous clear
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         done_flag     <= 1'b0;
         write_collision_flag_flag     <= 1'b0;
         ovf_flag      <= 1'b0;
         mode_fault_flag_flag     <= 1'b0;
         fault_disable <= 1'b0;
      end else begin
         done_flag <= xfer_done | (done_flag & ~clr_done);
         write_collision_flag_flag <= collide | (write_collision_flag_flag & ~clr_write_collision_flag);
         ovf_flag  <= overrun | (ovf_flag & ~clr_ovf);
         mode_fault_flag_flag <= fault | (mode_fault_flag_flag & ~clr_mode_fault_flag);
         if (stat_wr)
            fault_disable <= WDATA[`SPS_S_DISM];
      end
   end

   // read buffer keeps the old byte on overrun
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         rd_buf <= `SPS_DATA_RST;
      end else if (xfer_done & ~overrun) begin
         rd_buf <= rx_val;
      end
   end

   // one shifter for both modes; a write while idle goes straight into it
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         shifter <= `SPS_DATA_RST;
      end else if (load_ok) begin
         shifter <= WDATA;
      end else if (m_take | s_sample) begin
         shifter <= shifted;
      end else if (s_abort) begin
         shifter <= fill_ones(shifter, s_cnt, lsb);
      end
   end

   // bit presented on the outgoing line
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         out_bit <= 1'b0;
      end else if (m_start) begin
         out_bit <= top_bit(WDATA, lsb);
      end else if (s_ss_fall | m_launch | s_launch) begin
         out_bit <= top_bit(m_take ? shifted : shifter, lsb);
      end
   end

   // sample strobe delayed to meet the synchronised line at the top rate
   always @(posedge REF_CLK) begin
      if (SYS_RST | ~master | fault | cfg_abort) begin
         m_pipe <= 2'h0;
      end else begin
         m_pipe <= {m_pipe[0], m_sample};
      end
   end

   // master sequencer: lead-in, sixteen edges, tail
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         m_state  <= M_IDLE;
         div_cnt  <= 5'h00;
         edge_cnt <= 4'h0;
         sck_q    <= 1'b0;
         ss_q     <= 1'b1;
      end else if (~master | fault | cfg_abort) begin
         m_state  <= M_IDLE;
         div_cnt  <= 5'h00;
         edge_cnt <= 4'h0;
         sck_q    <= cpol;
         ss_q     <= 1'b1;
      end else begin
         case (m_state)
            M_IDLE: begin
               sck_q    <= cpol;
               div_cnt  <= 5'h00;
               edge_cnt <= 4'h0;
               if (m_start) begin
                  m_state <= M_LEAD;
                  ss_q    <= 1'b0;
               end else begin
                  ss_q    <= 1'b1;
               end
            end
            M_LEAD: begin
               if (tick) begin
                  m_state <= M_SHIFT;
                  div_cnt <= 5'h00;
               end else begin
                  div_cnt <= div_cnt + 5'h01;
               end
            end
            M_SHIFT: begin
               if (tick) begin
                  sck_q   <= ~sck_q;
                  div_cnt <= 5'h00;
                  if (edge_cnt == `SPS_EDGE_LAST)
                     m_state <= M_TAIL;
                  else
                     edge_cnt <= edge_cnt + 4'h1;
               end else begin
                  div_cnt <= div_cnt + 5'h01;
               end
            end
            M_TAIL: begin
               if (tick) begin
                  m_state <= M_IDLE;
                  div_cnt <= 5'h00;
                  ss_q    <= 1'b1;
               end else begin
                  div_cnt <= div_cnt + 5'h01;
               end
            end
            default: begin
               m_state <= M_IDLE;
            end
         endcase
      end
   end

   // slave bit counter and pin history
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         s_cnt <= 4'h0;
         sck_d <= 1'b1;
         ss_d  <= 1'b1;
      end else begin
         sck_d <= sck_s;
         ss_d  <= ss_s;
         if (~s_act)
            s_cnt <= 4'h0;
         else if (s_done)
            s_cnt <= 4'h0;
         else if (s_sample)
            s_cnt <= s_cnt + 4'h1;
      end
   end

   // read data stand only in the cycle after the strobe
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         RDATA <= 8'h00;
      end else if (RD) begin
         case (ADDR)
            `SPS_OFS_CTRL: RDATA <= ctrl;
            `SPS_OFS_STAT: RDATA <= {done_flag, write_collision_flag_flag, ovf_flag,
                                     mode_fault_flag_flag, fault_disable, 3'h0};
            `SPS_OFS_DATA: RDATA <= rd_buf;
            default:       RDATA <= 8'h00;
         endcase
      end else begin
         RDATA <= 8'h00;
      end
   end

   // pin drivers; enables are low while driving
   assign SCK_O     = sck_q;
   assign SCK_OE_N  = ~master;
   assign MOSI_O    = out_bit;
   assign MOSI_OE_N = ~master;
   assign MISO_O    = out_bit;
   // released when deselected so other slaves can share the line
   assign MISO_OE_N = ~s_act;
   assign SS_N_O    = ss_q;
   assign SS_N_OE_N = ~(master & fault_disable & select_output_enable);

endmodule

/* test/sps_peer.sv */
`timescale 1ns/100ps

module sps_peer (
   // pins seen
   input  wire       sck_pin,
   input  wire       ss_pin_n,
   input  wire       din,
   // pins driven
   output reg        sck,
   output reg        ss_n,
   output reg        dout,
   // setup
   input  wire       cpol,
   input  wire       cpha,
   input  wire       lsb,
   input  wire [7:0] tx,
   output reg  [7:0] rx
);
   integer k;

   function automatic [2:0] pos(input integer i);
      pos = lsb ? i[2:0] : 3'h7 - i[2:0];
   endfunction

   initial begin
      sck = 1'b0;
      ss_n = 1'b1;
      dout = 1'b0;
      rx = 8'h00;
      k = 0;
   end

   // select fall presents the first bit when sampling on the leading edge
   always @(negedge ss_pin_n) begin
      k = 0;
      if (!cpha)
         dout = tx[pos(0)];
   end

   // same polarity and phase as the port under test
   always @(sck_pin) if (!ss_pin_n && k < 8) begin
      if ((sck_pin != cpol) == cpha) begin
         if (!cpha)
            k = k + 1;
         if (k < 8)
            dout = tx[pos(k)];
      end else begin
         rx[pos(k)] = din;
         if (cpha)
            k = k + 1;
      end
   end

   // acting as master; fewer than eight clocks cuts the byte short
   task xfer(input integer n, input sel);
      integer i;
      begin
         sck = cpol;
         ss_n = !sel;
         #200;
         for (i = 0; i < n; i = i + 1) begin
            sck = !cpol;
            #200;
            sck = cpol;
            #200;
         end
         ss_n = 1'b1;
         #200;
      end
   endtask
endmodule

/* test/sps_top_chk.sv */
`timescale 1ns/100ps
`include "sps_defs.vh"

module sps_top_chk (
   // system
   input wire                   REF_CLK,
   input wire                   SYS_RST,
   // register port
   input wire [`SPS_ADDR_W-1:0] ADDR,
   input wire                   RD,
   input wire [7:0]             RDATA,
   // pins
   input wire                   SCK_O,
   input wire                   SCK_OE_N,
   input wire                   MOSI_OE_N,
   input wire                   MISO_OE_N,
   input wire                   SS_N_I,
   input wire                   SS_N_O,
   input wire                   SS_N_OE_N
);
   reg [4:0] edges;
   reg       sck_q;

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);

   // shift clock toggles inside one framed byte
   always @(posedge REF_CLK) begin
      sck_q <= SCK_O;
      if (SYS_RST || SS_N_O)
         edges <= 5'h00;
      else if (SCK_O != sck_q)
         edges <= edges + 5'h01;
   end

   a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
      else $error("read data not zero outside a read");
   a_rdata_unmapped: assert property
      ($past(RD) && $past(ADDR) == 2'h3 |-> RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_status_rsvd: assert property
      ($past(RD) && $past(ADDR) == `SPS_OFS_STAT |-> RDATA[2:0] == 3'h0)
      else $error("reserved status bits not zero");
   a_drv_excl: assert property (!MOSI_OE_N |-> MISO_OE_N)
      else $error("both data lines driven");
   a_slave_drive: assert property
      (!MISO_OE_N |-> SCK_OE_N && SS_N_OE_N)
      else $error("slave drives clock or select");
   a_slave_desel: assert property (SS_N_I [*4] |-> MISO_OE_N)
      else $error("slave drives while deselected");
   a_clk_rate: assert property
      (!SCK_OE_N && $changed(SCK_O) |=> SCK_OE_N || $stable(SCK_O))
      else $error("shift clock faster than a quarter");
   a_clk_count: assert property
      ($rose(SS_N_O) && !SS_N_OE_N |-> edges == 5'h10)
      else $error("byte frame without sixteen clock edges");
   a_clk_idle: assert property
      (!SS_N_OE_N && SS_N_O && $past(SS_N_O) && !$past(SS_N_OE_N)
       |-> $stable(SCK_O))
      else $error("shift clock moves between bytes");
   a_sel_frame: assert property
      ($fell(SS_N_O) && !SS_N_OE_N |-> !SS_N_O [*8] ##[20:300] SS_N_O)
      else $error("auto select frame wrong length");
endmodule

bind sps_top sps_top_chk u_sps_top_chk (
   .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .RD(RD),
   .RDATA(RDATA), .SCK_O(SCK_O), .SCK_OE_N(SCK_OE_N),
   .MOSI_OE_N(MOSI_OE_N), .MISO_OE_N(MISO_OE_N), .SS_N_I(SS_N_I),
   .SS_N_O(SS_N_O), .SS_N_OE_N(SS_N_OE_N)
);

/* test/sps_top_tb.sv */
`timescale 1ns/100ps
`include "sps_defs.vh"

module sps_top_tb;
   reg                   clk;
   reg                   rst;
   reg [`SPS_ADDR_W-1:0] addr;
   reg [7:0]             wdata;
   reg                   wr;
   reg                   rd;
   reg                   ss_ext_n;
   reg                   role_m;
   reg                   cpol;
   reg                   cpha;
   reg                   lsb;
   reg [7:0]             p_tx;
   reg [7:0]             v;
   reg [7:0]             b;
   reg [7:0]             cfg;
   wire [7:0]            p_rx;
   wire [7:0]            rdata;
   wire                  sck_o, sck_oe_n, mosi_o, mosi_oe_n;
   wire                  miso_o, miso_oe_n, ss_o, ss_oe_n;
   wire                  p_sck, p_ss_n, p_dout;
   integer               fail_count, total_checks, cycles, i, n;
   // released lines show the inverse of the last value, select pulls up
   wire sck_pin  = !sck_oe_n ? sck_o : p_sck;
   wire ss_pin   = !ss_oe_n ? ss_o : (p_ss_n & ss_ext_n);
   wire mosi_pin = !mosi_oe_n ? mosi_o : (role_m ? p_dout : ~p_dout);
   wire miso_pin = !miso_oe_n ? miso_o :
                   (!role_m && !ss_pin) ? p_dout : ~p_dout;

   sps_top u_sps_top (
      .REF_CLK(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .SCK_I(sck_pin), .SCK_O(sck_o),
      .SCK_OE_N(sck_oe_n), .MOSI_I(mosi_pin), .MOSI_O(mosi_o),
      .MOSI_OE_N(mosi_oe_n), .MISO_I(miso_pin), .MISO_O(miso_o),
      .MISO_OE_N(miso_oe_n), .SS_N_I(ss_pin), .SS_N_O(ss_o),
      .SS_N_OE_N(ss_oe_n)
   );

   sps_peer u_sps_peer (
      .sck_pin(sck_pin), .ss_pin_n(ss_pin),
      .din(role_m ? miso_pin : mosi_pin), .sck(p_sck), .ss_n(p_ss_n),
      .dout(p_dout), .cpol(cpol), .cpha(cpha), .lsb(lsb), .tx(p_tx),
      .rx(p_rx)
   );

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task chk(input string name, input [7:0] got, input [7:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
         end
      end
   endtask

   task wr_reg(input [1:0] a, input [7:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask

   task rd_reg(input [1:0] a, output [7:0] d);
      begin
         @(posedge clk);
         addr <= a;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         #1 d = rdata;
      end
   endtask

   // bounded poll of the completion flag
   task wait_done;
      begin
         n = 0;
         v = 8'h00;
         while (!v[`SPS_S_DONE] && n < 200) begin
            rd_reg(`SPS_OFS_STAT, v);
            n = n + 1;
         end
      end
   endtask

   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", total_checks, fail_count);
         if (fail_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask

   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         fail_count = fail_count + 1;
         end_of_test;
      end
   end

   initial begin
      rst = 1'b1;
      addr = 2'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      ss_ext_n = 1'b1;
      role_m = 1'b0;
      {cpol, cpha, lsb} = 3'h0;
      p_tx = 8'h00;
      fail_count = 0;
      total_checks = 0;
      cycles = 0;
      v = $urandom(32'hddff);
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 3; i = i + 1) begin
         rd_reg(i[1:0], v);
         chk("reset value", v, 8'h00);
      end
      wr_reg(2'h3, 8'hff);
      rd_reg(2'h3, v);
      chk("unmapped", v, 8'h00);
      // master: every clock format and rate, with a colliding write
      for (i = 0; i < 4; i = i + 1) begin
         {cpha, cpol} = i[1:0];
         lsb = i[0] ^ i[1];
         p_tx = $urandom;
         b = (i == 3) ? 8'h01 : $urandom;
         cfg = {1'b1, 1'b0, lsb, 1'b1, cpol, cpha, i[1:0]};
         wr_reg(`SPS_OFS_CTRL, cfg);
         wr_reg(`SPS_OFS_STAT, 8'hf8);
         wr_reg(`SPS_OFS_CTRL, cfg | 8'h40);
         wr_reg(`SPS_OFS_DATA, b);
         wr_reg(`SPS_OFS_DATA, ~b);
         wait_done;
         chk("master status", v, 8'hc8);
         rd_reg(`SPS_OFS_DATA, v);
         chk("master rx", v, p_tx);
         chk("peer rx", p_rx, b);
      end
      // select pin as general I/O, then as fault input
      wr_reg(`SPS_OFS_CTRL, 8'h00);
      wr_reg(`SPS_OFS_CTRL, 8'h50);
      repeat (2) @(posedge clk);
      #1 chk("select drive", {7'h00, ss_oe_n}, 8'h01);
      chk("clock drive", {7'h00, sck_oe_n}, 8'h00);
      wr_reg(`SPS_OFS_STAT, 8'hf0);
      ss_ext_n <= 1'b0;
      repeat (6) @(posedge clk);
      ss_ext_n <= 1'b1;
      rd_reg(`SPS_OFS_CTRL, v);
      chk("fault ctrl", v, 8'h00);
      rd_reg(`SPS_OFS_STAT, v);
      chk("fault status", v, 8'h10);
      // slave under the peer's clock
      wr_reg(`SPS_OFS_STAT, 8'hf0);
      role_m = 1'b1;
      {cpol, cpha, lsb} = 3'h5;
      wr_reg(`SPS_OFS_CTRL, 8'h28);
      wr_reg(`SPS_OFS_CTRL, 8'h68);
      b = $urandom;
      p_tx = $urandom;
      wr_reg(`SPS_OFS_DATA, b);
      u_sps_peer.xfer(8, 1'b0);
      rd_reg(`SPS_OFS_STAT, v);
      chk("unselected", v, 8'h00);
      u_sps_peer.xfer(8, 1'b1);
      rd_reg(`SPS_OFS_STAT, v);
      chk("slave status", v, 8'h80);
      rd_reg(`SPS_OFS_DATA, v);
      chk("slave rx", v, p_tx);
      chk("slave tx", p_rx, b);
      b = p_tx;
      p_tx = $urandom;
      u_sps_peer.xfer(8, 1'b1);
      rd_reg(`SPS_OFS_STAT, v);
      chk("overrun status", v, 8'ha0);
      rd_reg(`SPS_OFS_DATA, v);
      chk("kept byte", v, b);
      chk("overrun tx", p_rx, b);
      wr_reg(`SPS_OFS_STAT, 8'hf0);
      u_sps_peer.xfer(3, 1'b1);
      rd_reg(`SPS_OFS_STAT, v);
      chk("aborted", v, 8'h00);
      u_sps_peer.xfer(8, 1'b1);
      rd_reg(`SPS_OFS_STAT, v);
      chk("after abort", v, 8'h80);
      rd_reg(`SPS_OFS_DATA, v);
      chk("after abort rx", v, p_tx);
      chk("abort fill", p_rx, {5'h1f, p_tx[2:0]});
      end_of_test;
   end
endmodule
